// [verilog/gjpc_top.sv]
// Module: five configurable GPIO pins with game-port routing, APB register access
//
// Operation
// - Config bit 0: one input, zero output
// - Config bit 1 inverts pin to signal
// - Index 23 bit 2 routes joystick 1 button 1
// - Index 24 bit 2 routes joystick 1 button 2
// - Index 25 bit 2 routes joystick 2 button 1
// - Index 26 bit 2 routes joystick 2 button 2
// - Index 27 bit 2 routes joystick 1 X axis
// - Config bit 7: open drain, else push-pull
module gjpc_top #(
    parameter int unsigned ADDR_W = 12                   // APB address width
) (
    input  wire logic                pclk,               // 100 MHz clock
    input  wire logic                presetn,            // Standby power-on reset
    input  wire logic                psel,               // APB select
    input  wire logic                penable,            // APB access phase
    input  wire logic                pwrite,             // APB direction
    input  wire logic [ADDR_W-1:0]   paddr,              // APB byte address
    input  wire logic [31:0]         pwdata,             // APB write data
    output logic      [31:0]         prdata,             // APB read data
    output logic                     pready,             // APB ready
    output logic                     pslverr,            // APB error
    input  wire logic [4:0]          gpio_pin_in,        // Pin levels, bit 0 = pin a
    output logic      [4:0]          gpio_pin_out,       // Pin drive levels
    output logic      [4:0]          gpio_pin_oe,        // Pin output enables
    output logic                     joy1_button_first,  // Game port, from pin a
    output logic                     joy1_button_second, // Game port, from pin b
    output logic                     joy2_button_first,  // Game port, from pin c
    output logic                     joy2_button_second, // Game port, from pin d
    output logic                     joy1_x_axis_rc      // Game port, from pin e
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    gjpc_pkg::gjpc_cfg_t   cfg_ff [5];                   // Pin config registers
    logic [4:0]            data_ff;                      // Output data latch
    logic                  pready_ff;                    // Ready, one wait state
    logic                  pslverr_ff;                   // Error for unmapped index
    logic [31:0]           prdata_ff;                    // Captured read data
    logic [4:0]            pin_out_ff;                   // Registered drive level
    logic [4:0]            pin_oe_ff;                    // Registered output enable
    logic [4:0]            joy_ff;                       // Registered game signals
    logic [ADDR_W-3:0]     reg_idx;                      // Word index of access
    logic                  access_ph;                    // Access phase, not yet ready
    logic                  xfer_done;                    // Transfer completes this edge
    logic [4:0]            cfg_hit;                      // One-hot config decode
    logic                  data_hit;                     // Data register decode
    logic                  any_hit;                      // Index is mapped
    logic [4:0]            pin_adj;                      // Pin level after polarity
    logic [4:0]            drv_val;                      // Data after polarity
    logic [4:0]            rd_data;                      // Data register read view
    gjpc_pkg::gjpc_drive_t nxt_drive [5];                // Next drive per pin
    logic [31:0]           nxt_prdata;                   // Read mux
    logic [7:0]            cfg_idx [5];                  // Index table

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode
    assign reg_idx   = paddr[ADDR_W-1:2];
    // Access phase ends once ready has stood, so ready pulses one cycle
    assign access_ph = psel && penable && !pready_ff;
    assign xfer_done = psel && penable && pready_ff;
    // Config register index of each pin
    assign cfg_idx[0] = gjpc_pkg::IDX_CFG_JOY1_BUTTON1;
    assign cfg_idx[1] = gjpc_pkg::IDX_CFG_JOY1_BUTTON2;
    assign cfg_idx[2] = gjpc_pkg::IDX_CFG_JOY2_BUTTON1;
    assign cfg_idx[3] = gjpc_pkg::IDX_CFG_JOY2_BUTTON2;
    assign cfg_idx[4] = gjpc_pkg::IDX_CFG_JOY1_X_AXIS;

    // Address match per register
    always_comb
    begin
        for (int i = 0; i < 5; i++)
        begin
            cfg_hit[i] = (reg_idx == (ADDR_W-2)'(cfg_idx[i]));
        end
        data_hit = (reg_idx == (ADDR_W-2)'(gjpc_pkg::IDX_PIN_DATA));
        any_hit  = data_hit || (cfg_hit != 5'h0_0);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-pin polarity views
    always_comb
    begin
        for (int i = 0; i < 5; i++)
        begin
            pin_adj[i] = gpio_pin_in[i] ^ cfg_ff[i].pol;
            drv_val[i] = data_ff[i] ^ cfg_ff[i].pol;
            // Inputs show the pin, outputs show the latch
            rd_data[i] = cfg_ff[i].dir ? pin_adj[i] : data_ff[i];
        end
    end

    // Read mux; unmapped reads return zero
    always_comb
    begin
        nxt_prdata = 32'h0000_0000;
        if (data_hit)
        begin
            nxt_prdata[4:0] = rd_data;
        end
        for (int i = 0; i < 5; i++)
        begin
            if (cfg_hit[i])
            begin
                nxt_prdata[7:0] = cfg_ff[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB handshake: one wait state, ready for exactly one cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end
        else
        begin
            pready_ff  <= access_ph;
            pslverr_ff <= access_ph && !any_hit;
            // Read data captured as ready rises
            if (access_ph && !pwrite)
            begin
                prdata_ff <= nxt_prdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Config registers, written at transfer completion
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 5; i++)
            begin
                cfg_ff[i] <= gjpc_pkg::CFG_RESET;
            end
        end
        else if (xfer_done && pwrite)
        begin
            for (int i = 0; i < 5; i++)
            begin
                if (cfg_hit[i])
                begin
                    // Reserved bits dropped on write
                    cfg_ff[i] <= pwdata[7:0] & gjpc_pkg::CFG_WMASK;
                end
            end
        end
    end

    // Output data latch
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            data_ff <= gjpc_pkg::DATA_RESET;
        end
        else if (xfer_done && pwrite && data_hit)
        begin
            data_ff <= pwdata[4:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drive decision
    // A routed pin is never driven, so it cannot fight the joystick
    always_comb
    begin
        for (int i = 0; i < 5; i++)
        begin
            nxt_drive[i] = '0;
            if (cfg_ff[i].alt)
            begin
                // Routed pins are inputs to the game port
                nxt_drive[i] = '0;
            end
            else if (cfg_ff[i].dir)
            begin
                nxt_drive[i] = '0;
            end
            else if (cfg_ff[i].odrain)
            begin
                // Open drain pulls low only
                nxt_drive[i].out = 1'b0;
                nxt_drive[i].oe  = !drv_val[i];
            end
            else
            begin
                // Push-pull drives both levels
                nxt_drive[i].out = drv_val[i];
                nxt_drive[i].oe  = 1'b1;
            end
        end
    end

    // Registered pin drivers
    // Drivers follow config and data one cycle later
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_out_ff <= 5'h0_0;
            pin_oe_ff  <= 5'h0_0;
        end
        else
        begin
            for (int i = 0; i < 5; i++)
            begin
                pin_out_ff[i] <= nxt_drive[i].out;
                pin_oe_ff[i]  <= nxt_drive[i].oe;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Game-port routing
    // Unrouted game signals rest at the idle level
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            joy_ff <= {5{gjpc_pkg::JOY_IDLE}};
        end
        else
        begin
            joy_ff[0] <= cfg_ff[0].alt ? pin_adj[0] : gjpc_pkg::JOY_IDLE;
            joy_ff[1] <= cfg_ff[1].alt ? pin_adj[1] : gjpc_pkg::JOY_IDLE;
            joy_ff[2] <= cfg_ff[2].alt ? pin_adj[2] : gjpc_pkg::JOY_IDLE;
            joy_ff[3] <= cfg_ff[3].alt ? pin_adj[3] : gjpc_pkg::JOY_IDLE;
            joy_ff[4] <= cfg_ff[4].alt ? pin_adj[4] : gjpc_pkg::JOY_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign prdata             = prdata_ff;
    assign pready             = pready_ff;
    assign pslverr            = pslverr_ff;
    assign gpio_pin_out       = pin_out_ff;
    assign gpio_pin_oe        = pin_oe_ff;
    assign joy1_button_first  = joy_ff[0];
    assign joy1_button_second = joy_ff[1];
    assign joy2_button_first  = joy_ff[2];
    assign joy2_button_second = joy_ff[3];
    assign joy1_x_axis_rc     = joy_ff[4];

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    // Direction, polarity and drive
    input_no_drive_a : assert property (@(posedge pclk) disable iff (!presetn)
        cfg_ff[0].dir ##1 cfg_ff[0].dir |-> !gpio_pin_oe[0])
        else $error("Input pin a is driven");

    output_drives_a : assert property (@(posedge pclk) disable iff (!presetn)
        (!cfg_ff[1].dir && !cfg_ff[1].alt && !cfg_ff[1].odrain)
        |=> gpio_pin_oe[1])
        else $error("Push-pull output pin b not enabled");

    polarity_out_a : assert property (@(posedge pclk) disable iff (!presetn)
        (!cfg_ff[2].dir && !cfg_ff[2].alt && !cfg_ff[2].odrain)
        |=> gpio_pin_out[2] == ($past(data_ff[2]) ^ $past(cfg_ff[2].pol)))
        else $error("Pin c output level wrong for polarity");

    // Game-port routing and idle levels, then open drain, reads, writes and the bus handshake
    route_joy1_button_first_a : assert property (@(posedge pclk) disable iff (!presetn)
        cfg_ff[0].alt |=> joy1_button_first == ($past(gpio_pin_in[0]) ^ $past(cfg_ff[0].pol)))
        else $error("Pin a not routed to joystick 1 button 1");

    route_joy1_button_second_a : assert property (@(posedge pclk) disable iff (!presetn)
        cfg_ff[1].alt |=> joy1_button_second == ($past(gpio_pin_in[1]) ^ $past(cfg_ff[1].pol)))
        else $error("Pin b not routed to joystick 1 button 2");

    route_joy2_button_first_a : assert property (@(posedge pclk) disable iff (!presetn)
        cfg_ff[2].alt |=> joy2_button_first == ($past(gpio_pin_in[2]) ^ $past(cfg_ff[2].pol)))
        else $error("Pin c not routed to joystick 2 button 1");

    route_joy2_button_second_a : assert property (@(posedge pclk) disable iff (!presetn)
        cfg_ff[3].alt |=> joy2_button_second == ($past(gpio_pin_in[3]) ^ $past(cfg_ff[3].pol)))
        else $error("Pin d not routed to joystick 2 button 2");

    route_j1x_a : assert property (@(posedge pclk) disable iff (!presetn)
        !cfg_ff[4].alt |=> joy1_x_axis_rc == gjpc_pkg::JOY_IDLE)
        else $error("Pin e leaks to X axis in GPIO mode");

    open_drain_a : assert property (@(posedge pclk) disable iff (!presetn)
        (!cfg_ff[3].dir && !cfg_ff[3].alt && cfg_ff[3].odrain)
        |=> !gpio_pin_out[3] && (gpio_pin_oe[3] == !$past(drv_val[3])))
        else $error("Open-drain pin d drives high or wrong enable");

    read_input_a : assert property (@(posedge pclk) disable iff (!presetn)
        (access_ph && !pwrite && data_hit && cfg_ff[4].dir)
        |=> pready && prdata[4] == ($past(gpio_pin_in[4]) ^ $past(cfg_ff[4].pol)))
        else $error("Input pin e read without polarity");

    rsvd_write_a : assert property (@(posedge pclk) disable iff (!presetn)
        (xfer_done && pwrite && cfg_hit[0])
        |=> cfg_ff[0] == ($past(pwdata[7:0]) & gjpc_pkg::CFG_WMASK))
        else $error("Config write stored reserved bits");

    apb_ready_a : assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
        else $error("Ready not one wait state after setup");

    ready_pulse_a : assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("Ready stood longer than one cycle");

    slverr_map_a : assert property (@(posedge pclk) disable iff (!presetn)
        access_ph |=> pslverr == !$past(any_hit))
        else $error("Error flag does not match the address decode");

    data_write_a : assert property (@(posedge pclk) disable iff (!presetn)
        (xfer_done && pwrite && data_hit) |=> data_ff == $past(pwdata[4:0]))
        else $error("Data latch write lost");

    rd_latch_a : assert property (@(posedge pclk) disable iff (!presetn)
        (access_ph && !pwrite && data_hit && !cfg_ff[0].dir)
        |=> prdata[0] == $past(data_ff[0]))
        else $error("Output pin a read does not show the latch");

    rsvd_read_a : assert property (@(posedge pclk) disable iff (!presetn)
        (xfer_done && !pwrite && cfg_hit[1]) |-> prdata[6:3] == 4'h0)
        else $error("Reserved config bits of pin b read nonzero");

    od_low_only_a : assert property (@(posedge pclk) disable iff (!presetn)
        (!cfg_ff[0].dir && !cfg_ff[0].alt && cfg_ff[0].odrain) |=> !gpio_pin_out[0])
        else $error("Open-drain pin a drives a high level");

    alt_no_drive_a : assert property (@(posedge pclk) disable iff (!presetn)
        cfg_ff[2].alt |=> !gpio_pin_oe[2])
        else $error("Routed pin c is driven");

    joy_idle_b_a : assert property (@(posedge pclk) disable iff (!presetn)
        !cfg_ff[1].alt |=> joy1_button_second == gjpc_pkg::JOY_IDLE)
        else $error("Pin b leaks to joystick 1 button 2 in GPIO mode");

    route_j1x_on_a : assert property (@(posedge pclk) disable iff (!presetn)
        cfg_ff[4].alt |=> joy1_x_axis_rc == ($past(gpio_pin_in[4]) ^ $past(cfg_ff[4].pol)))
        else $error("Pin e not routed to the X axis");

endmodule : gjpc_top

// [verilog/gjpc_pkg.sv]
// Package: register map, field layout, reset values and carrier types for the pin block
package gjpc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int unsigned NUM_PINS   = 5;              // Pins a to e
    localparam int unsigned CFG_W      = 8;              // Config register width
    localparam int unsigned IDX_W      = 8;              // Register index width

    ////////////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_PIN_DATA         = 8'h00;  // Pin data register
    localparam logic [7:0]  IDX_CFG_JOY1_BUTTON1 = 8'h23;  // Pin a config
    localparam logic [7:0]  IDX_CFG_JOY1_BUTTON2 = 8'h24;  // Pin b config
    localparam logic [7:0]  IDX_CFG_JOY2_BUTTON1 = 8'h25;  // Pin c config
    localparam logic [7:0]  IDX_CFG_JOY2_BUTTON2 = 8'h26;  // Pin d config
    localparam logic [7:0]  IDX_CFG_JOY1_X_AXIS  = 8'h27;  // Pin e config

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions inside a config register
    localparam int unsigned BIT_DIR     = 0;             // 1 input, 0 output
    localparam int unsigned BIT_POL     = 1;             // 1 invert
    localparam int unsigned BIT_ALT     = 2;             // 1 game-port function
    localparam int unsigned BIT_ODRAIN  = 7;             // 1 open drain

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values and masks
    localparam logic [7:0]  CFG_RESET   = 8'h01;         // Input, no invert, GPIO
    localparam logic [7:0]  CFG_WMASK   = 8'h87;         // Writable config bits
    localparam logic [4:0]  DATA_RESET  = 5'h00;         // Output data latch
    localparam logic        JOY_IDLE    = 1'b1;          // Game signal when not routed

    ////////////////////////////////////////////////////////////////////////////////
    // Carrier: one pin configuration register
    typedef struct packed {
        logic       odrain;                              // Output driver type
        logic [3:0] rsvd;                                // Reserved, always zero
        logic       alt;                                 // Alternate function select
        logic       pol;                                 // Polarity invert
        logic       dir;                                 // Direction
    } gjpc_cfg_t;

    // Carrier: one pin drive decision
    typedef struct packed {
        logic       out;                                 // Pin output level
        logic       oe;                                  // Pin output enable
    } gjpc_drive_t;

endpackage : gjpc_pkg

// [bench/gjpc_pins_model.sv]
// Partner model: joystick buttons and pin loads seen by the five pins
module gjpc_pins_model (
    input  wire logic [4:0] pin_out,    // Drive levels from the block
    input  wire logic [4:0] pin_oe,     // Output enables from the block
    input  wire logic [4:0] ext_level,  // Level the far side puts on a free pin
    output logic      [4:0] pin_level   // Resolved wire level back to the block
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////////
    // Wire resolution: a driven pin shows the block, a released one the far side
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : gjpc_pins_model

// [bench/gpio_joystick_pin_config_test.sv]
// Testbench: configuration, drive, polarity and game-port routing of five pins
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
module gpio_joystick_pin_config_test;
    timeunit 1ns;
    timeprecision 1ps;

    // One ordinary case: config, data bit, far level and what the pin should show
    typedef struct packed {
        logic [7:0] cfg;   // Config written
        logic       dat;   // Data latch bit
        logic       ext;   // Far-side level
        logic       oe;    // Expected enable
        logic       out;   // Expected level when driven
        logic       joy;   // Expected game signal
        logic       rd;    // Expected data read bit
    } gjpc_row_t;

    logic        pclk, presetn, psel, penable, pwrite, pslverr, pready;  // Bus and reset
    logic [11:0] paddr;                      // Byte address
    logic [31:0] pwdata, prdata, q;          // Data
    logic [4:0]  pin_in, pin_out, pin_oe;    // Pin vectors
    logic [4:0]  ext, joy;                   // Far level, game signals
    logic        err;                        // Error of last transfer
    logic [4:0]  jexp;                       // Expected game signals
    int          failures, comparisons;      // Verdict counters
    gjpc_row_t   rows [11];                  // Ordinary cases

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, design and far side
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    gjpc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .gpio_pin_in(pin_in),
        .gpio_pin_out(pin_out), .gpio_pin_oe(pin_oe), .joy1_button_first(joy[0]),
        .joy1_button_second(joy[1]), .joy2_button_first(joy[2]),
        .joy2_button_second(joy[3]), .joy1_x_axis_rc(joy[4]));

    gjpc_pins_model far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext),
        .pin_level(pin_in));

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and run end
    task automatic test_done();
        if (failures == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    // One bus transfer, held until ready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            failures++;
            test_done();
        end
        q   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Let config, data and pin changes reach the outputs
    task automatic settle();
        repeat (4) @(posedge pclk);
        #1;
    endtask : settle

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        ext = 5'h1F;
        failures = 0;
        comparisons = 0;
        //         cfg     dat   ext   oe    out   joy   rd
        rows = '{'{8'h00, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1},
                 '{8'h02, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1},
                 '{8'h80, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1},
                 '{8'h80, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0},
                 '{8'h82, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1},
                 '{8'h01, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0},
                 '{8'h03, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1},
                 '{8'h05, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0},
                 '{8'h07, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1},
                 '{8'h06, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0},
                 '{8'hFF, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0}};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        // Every row on every pin; config word index 0x23 + pin
        for (int i = 0; i < 5; i++)
        begin
            for (int r = 0; r < 11; r++)
            begin
                apb(1'b1, 12'h08C + 12'(4 * i), {24'h0, rows[r].cfg});
                apb(1'b1, 12'h000, {27'h0, 5'(rows[r].dat) << i});
                @(posedge pclk);
                ext <= {5{rows[r].ext}};
                settle();
                `CHK(pin_oe[i], rows[r].oe)
                if (rows[r].oe)
                    `CHK(pin_out[i], rows[r].out)
                // Only the pin under test may leave the idle level
                jexp = rows[r].joy ? 5'h1F : 5'h1F ^ (5'h01 << i);
                `CHK(joy, jexp)
                apb(1'b0, 12'h000, 32'h0);
                `CHK(q[i], rows[r].rd)
                `CHK({err, q[31:5]}, 28'h000_0000)
                apb(1'b0, 12'h08C + 12'(4 * i), 32'h0);
                `CHK(q, {24'h0, rows[r].cfg & 8'h87})
            end
            apb(1'b1, 12'h08C + 12'(4 * i), 32'h0000_0001);
        end
        // Unmapped place: refused, reads zero, leaves the pin a config alone
        apb(1'b1, 12'h004, 32'hFFFF_FFFF);
        `CHK(err, 1'b1)
        apb(1'b0, 12'h004, 32'h0);
        `CHK({err, q}, {1'b1, 32'h0000_0000})
        apb(1'b0, 12'h08C, 32'h0);
        `CHK(q, 32'h0000_0001)
        // Mid-run reset while pin a drives and pin b is routed
        apb(1'b1, 12'h08C, 32'h0000_0000);
        apb(1'b1, 12'h090, 32'h0000_0007);
        settle();
        `CHK({pin_oe[0], joy[1]}, 2'h2)
        @(posedge pclk);
        presetn <= 1'b0;
        settle();
        `CHK(pin_oe, 5'h00)
        `CHK(joy, 5'h1F)
        `CHK({pready, pslverr, prdata}, 34'h0_0000_0000)
        @(posedge pclk);
        presetn <= 1'b1;
        // Outputs after release reflect the reset config
        settle();
        `CHK({pin_oe, pin_out, joy}, 15'h001F)
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, 12'h08C + 12'(4 * i), 32'h0);
            `CHK(q, 32'h0000_0001)
        end
        test_done();
    end
endmodule : gpio_joystick_pin_config_test
